// file: rtl/mmp_arb_slot.sv
`timescale 1ns/10ps
module mmp_arb_slot (
  // Clock, reset and freeze.
  input  wire logic clk_sys_in,
  input  wire logic reset_n_in,
  input  wire logic ce_in,
  // Arbitration.
  input  wire logic arb_edge_in,
  input  wire logic pri_in,
  input  wire logic want_in,
  input  wire logic bus_free_in,
  input  wire logic may_release_in,
  output logic      pri_out,
  output logic      own_out
);

  // The chain is combinational so a new request blocks lower slots within the same edge.
  assign pri_out = pri_in && !want_in;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      own_out <= 1'b0;
    end else if (ce_in && arb_edge_in) begin
      if (!own_out && pri_in && want_in && bus_free_in) begin
        own_out <= 1'b1;
      end else if (own_out && !want_in && may_release_in) begin
        own_out <= 1'b0;
      end
    end
  end

endmodule

// file: rtl/mmp_pkg.sv
package mmp_pkg;

  localparam int CLK_PERIOD_NS = 5;
  localparam int CCLK_MHZ      = 10;
  localparam int BCLK_MHZ      = 5;
  localparam int ADDR_SETUP_NS = 35;
  localparam int ADDR_HOLD_NS  = 35;

  localparam int CCLK_HALF_CYC  = 1000 / (2 * CCLK_MHZ * CLK_PERIOD_NS);
  localparam int BCLK_PER_CCLK  = CCLK_MHZ / BCLK_MHZ;
  localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_HOLD_CYC  = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [4:0] CCLK_LAST    = 5'(CCLK_HALF_CYC - 1);
  localparam logic       BCLK_PH_LAST = 1'(BCLK_PER_CCLK - 1);
  localparam logic [3:0] SETUP_LAST   = 4'(ADDR_SETUP_CYC - 1);
  localparam logic [3:0] HOLD_LAST    = 4'(ADDR_HOLD_CYC - 1);

  localparam int ADR_W    = 20;
  localparam int IO_ADR_W = 16;
  localparam int DAT_W    = 16;
  localparam int INT_W    = 8;
  localparam int SYNC_W   = DAT_W + INT_W + 3;

  localparam logic [ADR_W-1:0] ADR_OE_MEM = 20'h00000;
  localparam logic [ADR_W-1:0] ADR_OE_IO  = 20'hF0000;
  localparam logic [ADR_W-1:0] ADR_OE_OFF = 20'hFFFFF;
  localparam logic             LINE_IDLE  = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_CMD,
    ST_HOLD,
    ST_DONE
  } mmp_state_t;

  typedef struct packed {
    logic             write;
    logic             io;
    logic             byte_acc;
    logic             wide_card;
    logic [ADR_W-1:0] addr;
    logic [DAT_W-1:0] wdata;
  } mmp_req_t;

  typedef struct packed {
    logic [ADR_W-1:0] adr;
    logic [ADR_W-1:0] adr_oe_n;
    logic [DAT_W-1:0] dat;
    logic             dat_oe_n;
    logic             bhen_n;
    logic             bhen_oe_n;
    logic             mrdc_n;
    logic             mwtc_n;
    logic             iordc_n;
    logic             iowtc_n;
    logic             cmd_oe_n;
  } mmp_bus_t;

endpackage

// file: rtl/mmp_port.sv
`timescale 1ns/10ps
module mmp_port #(
  parameter int NREQ = 2
) (
  // Clock, reset and freeze.
  input  wire logic                                clk_sys_in,
  input  wire logic                                reset_n_in,
  input  wire logic                                ce_in,
  // Local requesters, index 0 has the higher priority.
  input  wire logic             [NREQ-1:0]         req_valid_in,
  input  wire mmp_pkg::mmp_req_t [NREQ-1:0]        req_in,
  output logic                  [NREQ-1:0]         done_out,
  output logic                  [NREQ-1:0]         owner_out,
  output logic                  [mmp_pkg::DAT_W-1:0] rdata_out,
  // Bus transfer lines.
  output mmp_pkg::mmp_bus_t                        bus_out,
  input  wire logic             [mmp_pkg::DAT_W-1:0] dat_in,
  input  wire logic                                xack_n_in,
  // Arbitration lines.
  input  wire logic                                bpri_n_in,
  output logic                                     bpro_n_out,
  input  wire logic                                busy_n_in,
  output logic                                     busy_n_out,
  output logic                                     busy_oe_n_out,
  // Bus clocks.
  output logic                                     cclk_n_out,
  output logic                                     bclk_n_out,
  // Interrupt lines.
  input  wire logic             [mmp_pkg::INT_W-1:0] int_n_in,
  output logic                  [mmp_pkg::INT_W-1:0] irq_out
);

  localparam int IDX_W = (NREQ > 1) ? $clog2(NREQ) : 1;

  logic [mmp_pkg::SYNC_W-1:0] sync_a;
  logic [mmp_pkg::SYNC_W-1:0] sync_b;
  logic [mmp_pkg::DAT_W-1:0]  dat_s;
  logic [mmp_pkg::INT_W-1:0]  int_n_s;
  logic                       xack_n_s;
  logic                       bpri_n_s;
  logic                       busy_n_s;
  logic [4:0]                 cclk_cnt;
  logic                       cclk_tick;
  logic                       bclk_ph;
  logic                       bclk_edge;
  logic [NREQ:0]              chain;
  logic [NREQ-1:0]            owner;
  logic                       owner_any;
  logic [IDX_W-1:0]           sel_idx;
  logic [IDX_W-1:0]           cur_idx;
  mmp_pkg::mmp_state_t        st;
  logic [3:0]                 cnt;
  mmp_pkg::mmp_req_t          cur;
  logic                       drv;
  logic                       odd_wide;

  // Every pin input is foreign to this clock and goes through two stages.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_a <= '1;
      sync_b <= '1;
    end else if (ce_in) begin
      sync_a <= {dat_in, int_n_in, xack_n_in, bpri_n_in, busy_n_in};
      sync_b <= sync_a;
    end
  end

  assign {dat_s, int_n_s, xack_n_s, bpri_n_s, busy_n_s} = sync_b;

  // Both bus clocks come from one counter so their edges stay aligned.
  assign cclk_tick = (cclk_cnt == mmp_pkg::CCLK_LAST);
  assign bclk_edge = cclk_tick && (bclk_ph == mmp_pkg::BCLK_PH_LAST) && bclk_n_out;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cclk_cnt   <= 5'h00;
      cclk_n_out <= mmp_pkg::LINE_IDLE;
      bclk_ph    <= 1'b0;
      bclk_n_out <= mmp_pkg::LINE_IDLE;
    end else if (ce_in) begin
      if (cclk_tick) begin
        cclk_cnt   <= 5'h00;
        cclk_n_out <= !cclk_n_out;
        if (bclk_ph == mmp_pkg::BCLK_PH_LAST) begin
          bclk_ph    <= 1'b0;
          bclk_n_out <= !bclk_n_out;
        end else begin
          bclk_ph <= bclk_ph + 1'b1;
        end
      end else begin
        cclk_cnt <= cclk_cnt + 5'h01;
      end
    end
  end

  // The upstream grant enters slot 0; each slot hands it on only while it does not want the bus.
  assign chain[0]   = !bpri_n_s;
  assign bpro_n_out = !chain[NREQ];
  assign owner_any  = |owner;
  assign owner_out  = owner;

  for (genvar i = 0; i < NREQ; i++) begin : g_slot
    mmp_arb_slot u_slot (
      .clk_sys_in     (clk_sys_in),
      .reset_n_in     (reset_n_in),
      .ce_in          (ce_in),
      .arb_edge_in    (bclk_edge),
      .pri_in         (chain[i]),
      .want_in        (req_valid_in[i]),
      .bus_free_in    (busy_n_s && !owner_any),
      .may_release_in (st == mmp_pkg::ST_IDLE),
      .pri_out        (chain[i+1]),
      .own_out        (owner[i])
    );
  end

  // The bus stays claimed for as long as any local slot owns it.
  assign busy_n_out    = 1'b0;
  assign busy_oe_n_out = !owner_any;

  always_comb begin
    sel_idx = '0;
    for (int i = 0; i < NREQ; i++) begin
      if (owner[i]) begin
        sel_idx = IDX_W'(i);
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st      <= mmp_pkg::ST_IDLE;
      cnt     <= 4'h0;
      cur     <= '0;
      cur_idx <= '0;
    end else if (ce_in) begin
      case (st)
        mmp_pkg::ST_IDLE: begin
          if (owner_any && req_valid_in[sel_idx]) begin
            cur     <= req_in[sel_idx];
            cur_idx <= sel_idx;
            cnt     <= 4'h0;
            st      <= mmp_pkg::ST_SETUP;
          end
        end
        mmp_pkg::ST_SETUP: begin
          cnt <= cnt + 4'h1;
          if (cnt == mmp_pkg::SETUP_LAST) begin
            cnt <= 4'h0;
            st  <= mmp_pkg::ST_CMD;
          end
        end
        mmp_pkg::ST_CMD: begin
          if (!xack_n_s) begin
            st <= mmp_pkg::ST_HOLD;
          end
        end
        mmp_pkg::ST_HOLD: begin
          cnt <= cnt + 4'h1;
          if (cnt == mmp_pkg::HOLD_LAST) begin
            cnt <= 4'h0;
            st  <= mmp_pkg::ST_DONE;
          end
        end
        mmp_pkg::ST_DONE: begin
          st <= mmp_pkg::ST_IDLE;
        end
        default: begin
          st <= mmp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign drv      = (st == mmp_pkg::ST_SETUP) || (st == mmp_pkg::ST_CMD) || (st == mmp_pkg::ST_HOLD);
  assign odd_wide = cur.addr[0] && cur.wide_card;

  // A 16-bit card takes an odd byte on the high lane; an 8-bit card wants it swapped low.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= 16'h0000;
    end else if (ce_in && st == mmp_pkg::ST_CMD && !xack_n_s && !cur.write) begin
      if (!cur.byte_acc) begin
        rdata_out <= dat_s;
      end else if (odd_wide) begin
        rdata_out <= {8'h00, dat_s[15:8]};
      end else begin
        rdata_out <= {8'h00, dat_s[7:0]};
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NREQ; i++) begin
      done_out[i] = (st == mmp_pkg::ST_DONE) && (cur_idx == IDX_W'(i));
    end
  end

  always_comb begin
    bus_out = '1;
    // I/O keeps the low sixteen lines, so 8-bit I/O slaves see their address unchanged.
    bus_out.adr = cur.io ? {4'h0, cur.addr[mmp_pkg::IO_ADR_W-1:0]} : cur.addr;
    if (!drv) begin
      bus_out.adr_oe_n = mmp_pkg::ADR_OE_OFF;
    end else if (cur.io) begin
      bus_out.adr_oe_n = mmp_pkg::ADR_OE_IO;
    end else begin
      bus_out.adr_oe_n = mmp_pkg::ADR_OE_MEM;
    end
    // Replicating a byte on both lanes serves either card width without knowing it.
    bus_out.dat       = cur.byte_acc ? {2{cur.wdata[7:0]}} : cur.wdata;
    bus_out.dat_oe_n  = !(drv && cur.write);
    bus_out.bhen_n    = !(!cur.byte_acc || odd_wide);
    bus_out.bhen_oe_n = !drv;
    bus_out.mrdc_n    = !(st == mmp_pkg::ST_CMD && !cur.io && !cur.write);
    bus_out.mwtc_n    = !(st == mmp_pkg::ST_CMD && !cur.io && cur.write);
    bus_out.iordc_n   = !(st == mmp_pkg::ST_CMD && cur.io && !cur.write);
    bus_out.iowtc_n   = !(st == mmp_pkg::ST_CMD && cur.io && cur.write);
    bus_out.cmd_oe_n  = !owner_any;
  end

  // Interrupts are plain levels; no acknowledge cycle is ever run.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_out <= 8'h00;
    end else if (ce_in) begin
      irq_out <= ~int_n_s;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_setup;
    (st == mmp_pkg::ST_SETUP && bus_out.adr_oe_n != mmp_pkg::ADR_OE_OFF)[*7];
  endsequence

  sequence s_hold;
    (st == mmp_pkg::ST_HOLD && bus_out.cmd_oe_n == 1'b0)[*7];
  endsequence

  a_cclk_toggle: assert property (
    !$stable(cclk_n_out) |-> $past(cclk_cnt) == 5'h09 && $past(ce_in))
    else $error("constant clock toggled off its half period");

  a_bclk_double: assert property (
    !$stable(bclk_n_out) |-> !$stable(cclk_n_out) && $past(bclk_ph))
    else $error("arbitration clock not at half the constant clock");

  a_single_owner: assert property (
    $onehot0(owner))
    else $error("two local owners at once");

  a_owner_edge: assert property (
    !$stable(owner) |-> $past(bclk_edge))
    else $error("ownership moved off an arbitration edge");

  a_chain_pass: assert property (
    !bpro_n_out |-> req_valid_in == '0 && !bpri_n_s)
    else $error("grant passed on while a local requester wants the bus");

  a_setup_time: assert property (
    $rose(st == mmp_pkg::ST_SETUP) |-> s_setup ##1 (st == mmp_pkg::ST_CMD))
    else $error("command came without full address setup");

  a_hold_time: assert property (
    (st == mmp_pkg::ST_CMD && !xack_n_s) |=> s_hold ##1 (st == mmp_pkg::ST_DONE) ##1
      (st == mmp_pkg::ST_IDLE && done_out == '0))
    else $error("address hold or completion out of step");

  a_io_upper_off: assert property (
    (drv && cur.io) |-> bus_out.adr_oe_n[19:16] == 4'hF && bus_out.adr[19:16] == 4'h0)
    else $error("I/O cycle drove upper address lines");

  a_no_slave_drive: assert property (
    !bus_out.dat_oe_n |-> cur.write && owner_any && drv)
    else $error("data lines driven outside an own write");

  a_narrow_lane: assert property (
    (drv && cur.byte_acc && !cur.wide_card) |-> bus_out.bhen_n &&
      bus_out.dat[15:8] == bus_out.dat[7:0])
    else $error("byte for an 8-bit card not on the low lane");

  a_irq_level: assert property (
    $past(ce_in) |-> irq_out == ~$past(int_n_s))
    else $error("interrupt level not passed straight through");

  a_byte_read_zero: assert property (
    (st == mmp_pkg::ST_DONE && !cur.write && cur.byte_acc) |-> rdata_out[15:8] == 8'h00)
    else $error("byte read left data on the high half");

  a_done_pulse: assert property (
    (|done_out && ce_in) |=> done_out == '0)
    else $error("done pulse stood longer than one cycle");

endmodule

// file: test/mmp_bus_slave.sv
`timescale 1ns/10ps
module mmp_bus_slave (
  // Clock.
  input  wire logic               clk_sys_in,
  // Card side of the bus.
  input  wire mmp_pkg::mmp_bus_t  bus_in,
  input  wire logic [3:0]         lat_in,
  output logic [15:0]             dat_out,
  output logic                    xack_n_out,
  output mmp_pkg::mmp_bus_t       seen_out
);
  logic [3:0]  wait_cnt = 4'h0;
  logic [15:0] last_dat = 16'h0000;
  logic        rd_on;
  logic        cmd_on;
  logic [19:0] adr_seen;

  assign rd_on    = !bus_in.mrdc_n || !bus_in.iordc_n;
  assign cmd_on   = rd_on || !bus_in.mwtc_n || !bus_in.iowtc_n;
  assign adr_seen = bus_in.adr & ~bus_in.adr_oe_n;
  // Released data lines show a changing pattern, never the last value.
  assign dat_out  = rd_on ? {adr_seen[7:0] ^ 8'h5A, adr_seen[15:8] ^ adr_seen[19:12]}
                          : ~last_dat;

  initial xack_n_out = 1'b1;

  always @(posedge clk_sys_in) begin
    last_dat <= dat_out;
    if (!cmd_on) begin
      wait_cnt   <= 4'h0;
      xack_n_out <= 1'b1;
    end else begin
      if (wait_cnt == 4'h0) begin
        seen_out <= bus_in;
      end
      if (wait_cnt != 4'hF) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
      xack_n_out <= (wait_cnt < lat_in);
    end
  end
endmodule

// file: test/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic                     clk_sys_in    = 1'b0;
  logic                     reset_n_in    = 1'b0;
  logic                     ce_in         = 1'b1;
  logic [1:0]               req_valid_in  = 2'h0;
  mmp_pkg::mmp_req_t [1:0]  req_in        = '0;
  logic [1:0]               done_out;
  logic [1:0]               owner_out;
  logic [15:0]              rdata_out;
  mmp_pkg::mmp_bus_t        bus_out;
  mmp_pkg::mmp_bus_t        seen;
  logic [15:0]              dat_in;
  logic [15:0]              slv_dat;
  logic                     xack_n_in;
  logic                     bpri_n_in     = 1'b0;
  logic                     bpro_n_out;
  logic                     busy_n_in;
  logic                     busy_n_out;
  logic                     busy_oe_n_out;
  logic                     foreign_busy  = 1'b0;
  logic                     cclk_n_out;
  logic                     bclk_n_out;
  logic [7:0]               int_n_in      = 8'hFF;
  logic [7:0]               irq_out;
  logic [3:0]               lat           = 4'h0;
  int                       failures      = 0;
  int                       checked       = 0;

  always #2.5 clk_sys_in = ~clk_sys_in;

  // Shared lines resolve from the port's and the foreign owner's drive enables; the card model drives data otherwise.
  assign dat_in    = bus_out.dat_oe_n ? slv_dat : bus_out.dat;
  assign busy_n_in = busy_oe_n_out & !foreign_busy;

  mmp_port #(.NREQ(2)) dut (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .done_out(done_out),
    .owner_out(owner_out), .rdata_out(rdata_out), .bus_out(bus_out),
    .dat_in(dat_in), .xack_n_in(xack_n_in), .bpri_n_in(bpri_n_in),
    .bpro_n_out(bpro_n_out), .busy_n_in(busy_n_in), .busy_n_out(busy_n_out),
    .busy_oe_n_out(busy_oe_n_out), .cclk_n_out(cclk_n_out),
    .bclk_n_out(bclk_n_out), .int_n_in(int_n_in), .irq_out(irq_out)
  );

  mmp_bus_slave slave (
    .clk_sys_in(clk_sys_in), .bus_in(bus_out), .lat_in(lat),
    .dat_out(slv_dat), .xack_n_out(xack_n_in), .seen_out(seen)
  );

  task automatic complete_run();
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    checked++;
    if (seen_v !== exp_v) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask

  // Read data as the card model returns it, after lane steering.
  function automatic logic [15:0] exp_read(input mmp_pkg::mmp_req_t r);
    logic [15:0] w;
    w = {r.addr[7:0] ^ 8'h5A, r.addr[15:8] ^ r.addr[19:12]};
    if (!r.byte_acc)
      return w;
    return (r.addr[0] && r.wide_card) ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction

  task automatic period(input logic sel, input int exp_n);
    logic prev;
    int   n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      prev = sel ? bclk_n_out : cclk_n_out;
      do begin
        @(posedge clk_sys_in);
        #1;
        n++;
      end while ((sel ? bclk_n_out : cclk_n_out) === prev && n < 100);
    end
    check(n, exp_n);
  endtask

  task automatic wait_own(input logic [1:0] e);
    int n;
    n = 0;
    while (owner_out !== e && n < 300) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    check(owner_out, e);
  endtask

  // Waits for the done pulse, then drops valid at the edge closing it.
  task automatic finish_req(input int i);
    int n;
    n = 0;
    while (done_out[i] !== 1'b1 && n < 600) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    check(done_out[i], 1'h1);
    @(posedge clk_sys_in);
    req_valid_in[i] <= 1'b0;
  endtask

  task automatic xfer(input int i, input mmp_pkg::mmp_req_t r);
    logic [19:0] oe;
    @(posedge clk_sys_in);
    req_in[i] <= r;
    req_valid_in[i] <= 1'b1;
    #1;
    finish_req(i);
    oe = r.io ? mmp_pkg::ADR_OE_IO : mmp_pkg::ADR_OE_MEM;
    check(seen.adr_oe_n, oe);
    check(seen.adr & ~oe, r.addr);
    check({seen.mrdc_n, seen.mwtc_n, seen.iordc_n, seen.iowtc_n},
          4'(~(4'h8 >> {r.io, r.write})));
    check(seen.bhen_n, r.byte_acc ? !(r.addr[0] && r.wide_card) : 1'b0);
    check({seen.bhen_oe_n, seen.cmd_oe_n}, 2'h0);
    check(seen.dat_oe_n, !r.write);
    if (r.write)
      check(seen.dat, r.byte_acc ? {2{r.wdata[7:0]}} : r.wdata);
    else
      check(rdata_out, exp_read(r));
  endtask

  initial begin
    int                seed;
    int                i;
    mmp_pkg::mmp_req_t r;
    logic              frz;
    seed = $urandom(27);
    repeat (5) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    period(1'b0, 10);
    period(1'b1, 20);
    check(bpro_n_out, 1'h0);
    r = '{write: 1'b0, io: 1'b0, byte_acc: 1'b0, wide_card: 1'b1,
          addr: 20'hABCDE, wdata: 16'h0000};
    // Without the upstream grant, or with a foreign owner, nothing is taken.
    @(posedge clk_sys_in);
    bpri_n_in <= 1'b1;
    req_in[0] <= r;
    req_valid_in[0] <= 1'b1;
    repeat (90) @(posedge clk_sys_in);
    check(owner_out, 2'h0);
    check(bpro_n_out, 1'h1);
    bpri_n_in <= 1'b0;
    foreign_busy <= 1'b1;
    repeat (90) @(posedge clk_sys_in);
    check(owner_out, 2'h0);
    check(busy_oe_n_out, 1'h1);
    foreign_busy <= 1'b0;
    r.write = 1'b1;
    req_in[1] <= r;
    req_valid_in[1] <= 1'b1;
    #1;
    check(bpro_n_out, 1'h1);
    wait_own(2'h1);
    check({busy_oe_n_out, busy_n_out}, 2'h0);
    finish_req(0);
    wait_own(2'h2);
    finish_req(1);
    // Every command kind, byte accesses against both card widths and word accesses against 16-bit cards only.
    for (int k = 0; k < 16; k++) begin
      r.write = k[0];
      r.io = k[1];
      r.byte_acc = k[2];
      r.wide_card = !k[2] || k[3];
      r.addr = 20'($urandom);
      r.wdata = 16'($urandom);
      if (r.io)
        r.addr[19:16] = 4'h0;
      if (!r.byte_acc)
        r.addr[0] = 1'b0;
      i = $urandom_range(1, 0);
      @(posedge clk_sys_in);
      lat <= 4'($urandom_range(5, 0));
      int_n_in <= 8'($urandom);
      xfer(i, r);
      check(irq_out, 8'(~int_n_in));
    end
    // A low enable must hold every register, the constant clock included.
    @(posedge clk_sys_in);
    ce_in <= 1'b0;
    #1;
    frz = cclk_n_out;
    repeat (29) @(posedge clk_sys_in);
    check(cclk_n_out, frz);
    ce_in <= 1'b1;
    period(1'b0, 10);
    complete_run();
  end

  initial begin
    repeat (40000) @(posedge clk_sys_in);
    failures++;
    complete_run();
  end
endmodule
